// ===== rtl/sor_output_routing.sv
`timescale 1ns/1ps
module sor_output_routing #(
	parameter int START_CYC = sor_pkg::START_WIN_CYC,
	parameter int WDOG_LIM  = sor_pkg::WDOG_CYC
) (
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_rstn,
	input  wire logic                          i_ce,
	input  wire logic [sor_pkg::RES_W-1:0]     i_bridge_res,
	input  wire logic [sor_pkg::RES_W-1:0]     i_temp1_res,
	input  wire logic [sor_pkg::RES_W-1:0]     i_temp2_res,
	input  wire logic                          i_res_valid,
	input  wire logic [sor_pkg::CFG_W-1:0]     i_out_cfg,
	input  wire logic                          i_spi_sel,
	input  wire logic                          i_start_win_en,
	input  wire logic [1:0]                    i_dac_src,
	input  wire logic [1:0]                    i_pulse_src,
	input  wire logic [3:0]                    i_pulse_res,
	input  wire logic [7:0]                    i_pulse_div,
	input  wire sor_pkg::sor_cmp_cfg_t         i_cmp_a_cfg,
	input  wire sor_pkg::sor_cmp_cfg_t         i_cmp_b_cfg,
	input  wire logic                          i_ow_request,
	input  wire logic                          i_ow_set_exit,
	input  wire logic                          i_spi_busy,
	input  wire logic                          i_spi_sdo,
	input  wire logic                          i_spi_ss_n_pin,
	input  wire logic                          i_ctrl_alive,
	input  wire logic                          i_loop_tick,
	input  wire sor_pkg::sor_err_in_t          i_err,
	output logic [sor_pkg::DAC_W-1:0]          o_dac_code,
	output logic                               o_dac_en,
	output logic                               o_main_pulse_en,
	output logic                               o_main_pin_driver,
	output logic                               o_dual_pin_driver,
	output logic                               o_dual_use_pin_a_oe,
	output logic                               o_dual_use_pin_b_oe,
	output logic                               o_dual_use_pin_b,
	output logic                               o_onewire_active,
	output logic [1:0]                         o_serial_if,
	output logic                               o_command_mode,
	output logic                               o_spi_ss_n,
	output logic                               o_first_threshold_flag,
	output logic                               o_second_threshold_flag,
	output logic                               o_diag_mode,
	output logic                               o_ctrl_err_flag,
	output logic [7:0]                         o_err_code,
	output logic                               o_cfg_err
);
	import sor_pkg::*;

	typedef enum logic [1:0] {
		ST_START,
		ST_ONEWIRE,
		ST_RUN
	} sor_phase_t;

	typedef struct packed {
		sor_phase_t       phase;
		logic [WIN_W-1:0] win_cnt;
		logic [16:0]      wdog_cnt;
		logic [2:0]       req_sync;
		logic [2:0]       alive_sync;
		logic [2:0]       tick_sync;
		logic             alive_seen;
		logic             tick_seen;
		logic [1:0]       ss_sync;
		logic             diag;
		logic [7:0]       code;
		logic [DAC_W-1:0] dac;
		logic             dac_en;
		logic             main_pulse_en;
		logic             main_pin;
		logic             pin_a;
		logic             pin_a_oe;
		logic             pin_b;
		logic             pin_b_oe;
		logic             flag_a;
		logic             flag_b;
		logic             ss_n;
		logic             cfg_err;
		logic             ctrl_err;
	} sor_state_t;

	// reset image: select input sync and select output idle high, everything else cleared
	localparam sor_state_t STATE_RST = '{phase: ST_START, code: ERR_NONE,
		dac: DAC_MIN, ss_sync: 2'b11, ss_n: 1'b1, default: '0};

	sor_state_t st_reg;
	sor_state_t st_next;
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	sor_route_t route;
	logic       cmd_mode;
	logic       pulse_out;
	logic       pulse_hold;
	logic       cmp_a;
	logic       cmp_b;
	logic       wdog_hit;
	logic [RES_W-1:0] dac_val;
	logic [RES_W-1:0] pulse_val;

	// reset release through two flops, everything else uses the copy
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	function automatic logic [RES_W-1:0] pick(input logic [1:0] s,
		input logic [RES_W-1:0] b, input logic [RES_W-1:0] t1,
		input logic [RES_W-1:0] t2);
		case (s)
			2'(SOR_SRC_TEMP1): pick = t1;
			2'(SOR_SRC_TEMP2): pick = t2;
			default:           pick = b;
		endcase
	endfunction : pick

	always_comb begin
		route     = sor_route(i_out_cfg);
		dac_val   = pick(i_dac_src, i_bridge_res, i_temp1_res, i_temp2_res);
		pulse_val = pick(i_pulse_src, i_bridge_res, i_temp1_res, i_temp2_res);
		// only spi traffic on the live pin a counts as command mode
		cmd_mode  = route.spi && i_spi_busy;
		pulse_hold = (route.a_use == 2'(SOR_A_PULSE)) && route.spi &&
			(cmd_mode || !route.mode_dep);
		wdog_hit  = (st_reg.wdog_cnt >= 17'(WDOG_LIM));
	end

	// pulse resolution clamped to the 12-bit maximum
	sor_pulse_gen #(.MAX_W(PWM_MAX_W)) u_pulse (
		.i_sys_clk  (i_sys_clk),
		.i_rst_n    (rst_n),
		.i_ce       (i_ce),
		.i_hold     (pulse_hold),
		.i_res_bits ((i_pulse_res > 4'hc) ? 4'hc : i_pulse_res),
		.i_clk_div  (i_pulse_div),
		.i_duty     (pulse_val[RES_W-1 -: PWM_MAX_W] >> (4'hc - ((i_pulse_res > 4'hc) ? 4'hc : i_pulse_res))),
		.o_pulse    (pulse_out)
	);

	// both channels watch only the bridge result
	sor_threshold_cmp u_cmp_a (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_n),
		.i_ce      (i_ce),
		.i_sample  (i_res_valid),
		.i_value   (i_bridge_res),
		.i_cfg     (i_cmp_a_cfg),
		.o_flag    (cmp_a)
	);

	sor_threshold_cmp u_cmp_b (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_n),
		.i_ce      (i_ce),
		.i_sample  (i_res_valid),
		.i_value   (i_bridge_res),
		.i_cfg     (i_cmp_b_cfg),
		.o_flag    (cmp_b)
	);

	always_comb begin
		st_next = st_reg;
		st_next.req_sync   = {st_reg.req_sync[1:0], i_ow_request};
		st_next.alive_sync = {st_reg.alive_sync[1:0], i_ctrl_alive};
		st_next.tick_sync  = {st_reg.tick_sync[1:0], i_loop_tick};
		st_next.ss_sync    = {st_reg.ss_sync[0], i_spi_ss_n_pin};

		case (st_reg.phase)
			ST_START: begin
				if (!i_start_win_en) begin
					st_next.phase = ST_RUN;
				end else if (st_reg.req_sync[1]) begin
					st_next.phase = ST_ONEWIRE;
				end else if (st_reg.win_cnt >= WIN_W'(START_CYC - 1)) begin
					st_next.phase = ST_RUN;
				end else begin
					st_next.win_cnt = st_reg.win_cnt + 1'b1;
				end
			end
			ST_ONEWIRE: begin
				if (i_ow_set_exit) begin
					st_next.phase = ST_RUN;
				end
			end
			ST_RUN: st_next.phase = ST_RUN;
			default: st_next.phase = ST_START;
		endcase

		// watchdog: heartbeat and loop tick each seen once per span, in any
		// order, so two unrelated toggles never have to coincide
		st_next.alive_seen = st_reg.alive_seen |
			(st_reg.alive_sync[2] ^ st_reg.alive_sync[1]);
		st_next.tick_seen  = st_reg.tick_seen |
			(st_reg.tick_sync[2] ^ st_reg.tick_sync[1]);
		if (st_next.alive_seen && st_next.tick_seen) begin
			st_next.wdog_cnt   = '0;
			st_next.alive_seen = 1'b0;
			st_next.tick_seen  = 1'b0;
		end else if (!wdog_hit) begin
			st_next.wdog_cnt = st_reg.wdog_cnt + 1'b1;
		end

		st_next.cfg_err  = st_reg.cfg_err | !sor_cfg_ok(i_out_cfg) |
			(route.spi != i_spi_sel);
		st_next.ctrl_err = st_reg.ctrl_err | i_err.parity_fail |
			i_err.sig_fail;

		if (!st_reg.diag) begin
			if (wdog_hit) begin
				st_next.diag = 1'b1;
				st_next.code = ERR_WDOG;
			end else if (i_err.wire_p_bad || i_err.wire_n_bad) begin
				st_next.diag = 1'b1;
				st_next.code = ERR_WIRE;
			end else if (i_err.sensor_aging) begin
				st_next.diag = 1'b1;
				st_next.code = ERR_AGE;
			end else if (i_err.mem_fail) begin
				st_next.diag = 1'b1;
				st_next.code = ERR_MEM;
			end else if (i_err.parity_fail || i_err.sig_fail) begin
				st_next.diag = 1'b1;
				st_next.code = ERR_SIG;
			end else if (st_reg.cfg_err) begin
				st_next.diag = 1'b1;
				st_next.code = ERR_CFG;
			end
		end

		// main pin: one-wire owns it until the run phase
		st_next.dac_en        = (st_reg.phase == ST_RUN) &&
			(route.main_use == 2'(SOR_PIN_ANALOG));
		st_next.main_pulse_en = (st_reg.phase == ST_RUN) &&
			(route.main_use == 2'(SOR_PIN_PULSE)) && !st_reg.diag;
		st_next.main_pin      = st_next.main_pulse_en & pulse_out;
		if (st_reg.diag) begin
			st_next.dac = i_err.err_high ? DAC_MAX : DAC_MIN;
		end else begin
			st_next.dac = dac_val[RES_W-1 -: DAC_W];
		end

		st_next.flag_a = cmp_a;
		st_next.flag_b = cmp_b && route.b_flag && !route.spi;
		st_next.ss_n   = route.spi ? st_reg.ss_sync[1] : 1'b1;

		// pin a and pin b per configuration and spi activity
		st_next.pin_a_oe = (st_reg.phase == ST_RUN);
		st_next.pin_a    = 1'b0;
		if (route.spi && (cmd_mode || !route.mode_dep)) begin
			st_next.pin_a = i_spi_sdo;
		end else if (route.a_use == 2'(SOR_A_FLAG) || route.mode_dep) begin
			st_next.pin_a = (route.a_use == 2'(SOR_A_PULSE)) ? pulse_out :
				cmp_a;
		end else if (route.a_use == 2'(SOR_A_PULSE)) begin
			st_next.pin_a = pulse_out;
		end else begin
			st_next.pin_a_oe = 1'b0;
		end
		st_next.pin_b_oe = (st_reg.phase == ST_RUN) && !route.spi &&
			route.b_flag;
		st_next.pin_b    = cmp_b;
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= STATE_RST;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_dac_code              = st_reg.dac;
	assign o_dac_en                = st_reg.dac_en;
	assign o_main_pulse_en         = st_reg.main_pulse_en;
	assign o_main_pin_driver       = st_reg.main_pin;
	assign o_dual_pin_driver       = st_reg.pin_a;
	assign o_dual_use_pin_a_oe     = st_reg.pin_a_oe;
	assign o_dual_use_pin_b_oe     = st_reg.pin_b_oe;
	assign o_dual_use_pin_b        = st_reg.pin_b;
	assign o_onewire_active        = (st_reg.phase != ST_RUN);
	assign o_serial_if             = (st_reg.phase != ST_RUN) ? 2'(SOR_IF_ONEWIRE) :
		(i_spi_sel ? 2'(SOR_IF_SPI) : 2'(SOR_IF_I2C));
	assign o_command_mode          = (st_reg.phase == ST_ONEWIRE);
	assign o_spi_ss_n              = st_reg.ss_n;
	assign o_first_threshold_flag  = st_reg.flag_a;
	assign o_second_threshold_flag = st_reg.flag_b;
	assign o_diag_mode             = st_reg.diag;
	assign o_ctrl_err_flag         = st_reg.ctrl_err;
	assign o_err_code              = st_reg.code;
	assign o_cfg_err               = st_reg.cfg_err;

	sequence s_req_seen;
		st_reg.phase == ST_START && st_reg.req_sync[1] && i_start_win_en && i_ce;
	endsequence

	a_req_keeps_ow: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		s_req_seen |=> o_command_mode)
		else $error("request did not hold one-wire");
	a_skip_window: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		st_reg.phase == ST_START && !i_start_win_en && i_ce |=> !o_onewire_active)
		else $error("start window not skipped");
	a_ow_stays: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		o_command_mode && !i_ow_set_exit |=> o_command_mode)
		else $error("one-wire left without command");
	a_diag_level: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		o_diag_mode && i_ce |=> o_dac_code == DAC_MAX || o_dac_code == DAC_MIN)
		else $error("diagnostic level wrong");
	a_no_flag_b_spi: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		route.spi && $stable(route) |=> !o_second_threshold_flag)
		else $error("second flag in spi mode");
	a_dac_main_only: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		o_dac_en |-> !o_main_pulse_en)
		else $error("dac and pulse share main pin");
	a_wire_diag: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_ce && i_err.wire_p_bad ##1 i_ce |-> o_diag_mode)
		else $error("broken wire not diagnosed");
	a_ctrl_err_sticky: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		o_ctrl_err_flag |=> o_ctrl_err_flag)
		else $error("controller error flag dropped");

endmodule : sor_output_routing

// ===== include/sor_pkg.sv
package sor_pkg;

	localparam int RES_W      = 15;
	localparam int DAC_W      = 11;
	localparam int PWM_MAX_W  = 12;
	localparam int PWM_FAST_W = 9;
	localparam int CFG_W      = 5;
	localparam int NUM_CFG    = 27;
	localparam int NUM_I2C    = 18;
	localparam int DLY_W      = 8;

	// start window, printed in ms, counted at the 100 MHz clock
	localparam int  START_WIN_MS  = 20;
	localparam int  CLK_KHZ       = 100_000;
	localparam int  START_WIN_CYC = START_WIN_MS * CLK_KHZ;
	localparam int  WDOG_CYC      = 65_536;
	localparam int  WIN_W         = 22;

	localparam logic [RES_W-1:0] RES_RST   = 15'h0000;
	localparam logic [DAC_W-1:0] DAC_MAX   = 11'h07ff;
	localparam logic [DAC_W-1:0] DAC_MIN   = 11'h0000;
	localparam logic [7:0]       ERR_NONE  = 8'h00;
	localparam logic [7:0]       ERR_WDOG  = 8'h01;
	localparam logic [7:0]       ERR_WIRE  = 8'h02;
	localparam logic [7:0]       ERR_AGE   = 8'h03;
	localparam logic [7:0]       ERR_MEM   = 8'h04;
	localparam logic [7:0]       ERR_SIG   = 8'h05;
	localparam logic [7:0]       ERR_CFG   = 8'h06;

	typedef enum logic [1:0] {
		SOR_SRC_BRIDGE,
		SOR_SRC_TEMP1,
		SOR_SRC_TEMP2
	} sor_src_t;

	typedef enum logic [1:0] {
		SOR_IF_ONEWIRE,
		SOR_IF_I2C,
		SOR_IF_SPI
	} sor_if_t;

	typedef enum logic [1:0] {
		SOR_PIN_NONE,
		SOR_PIN_ANALOG,
		SOR_PIN_PULSE
	} sor_main_use_t;

	typedef enum logic [1:0] {
		SOR_A_NONE,
		SOR_A_FLAG,
		SOR_A_PULSE,
		SOR_A_SDO
	} sor_a_use_t;

	typedef struct packed {
		logic       spi;
		logic [1:0] main_use;
		logic [1:0] a_use;
		logic       b_flag;
		logic       mode_dep;
	} sor_route_t;

	typedef struct packed {
		logic [RES_W-1:0] thr_lo;
		logic [RES_W-1:0] thr_hi;
		logic [RES_W-1:0] hyst;
		logic             invert;
		logic             window;
		logic [DLY_W-1:0] on_dly;
		logic [DLY_W-1:0] off_dly;
	} sor_cmp_cfg_t;

	typedef struct packed {
		logic wire_p_bad;
		logic wire_n_bad;
		logic sensor_aging;
		logic mem_fail;
		logic parity_fail;
		logic sig_fail;
		logic err_high;
	} sor_err_in_t;

	// decodes a configuration number into the pins it uses
	function automatic sor_route_t sor_route(input logic [CFG_W-1:0] n);
		sor_route_t r;
		int         k;
		r = '0;
		if (n >= 5'h01 && n <= 5'h12) begin
			k = int'(n) - 1;
			r.main_use = (k / 6 == 0) ? 2'(SOR_PIN_NONE) :
				(k / 6 == 1) ? 2'(SOR_PIN_ANALOG) : 2'(SOR_PIN_PULSE);
			case (k % 6)
				1: r.a_use = 2'(SOR_A_FLAG);
				2: r.b_flag = 1'b1;
				3: begin
					r.a_use = 2'(SOR_A_FLAG);
					r.b_flag = 1'b1;
				end
				4: r.a_use = 2'(SOR_A_PULSE);
				5: begin
					r.a_use = 2'(SOR_A_PULSE);
					r.b_flag = 1'b1;
				end
				default: r.a_use = 2'(SOR_A_NONE);
			endcase
		end else if (n >= 5'h13 && n <= 5'h1b) begin
			k = int'(n) - 19;
			r.spi = 1'b1;
			r.main_use = (k / 3 == 0) ? 2'(SOR_PIN_NONE) :
				(k / 3 == 1) ? 2'(SOR_PIN_ANALOG) : 2'(SOR_PIN_PULSE);
			r.mode_dep = (k % 3 != 0);
			r.a_use = (k % 3 == 2) ? 2'(SOR_A_PULSE) :
				(k % 3 == 1) ? 2'(SOR_A_FLAG) : 2'(SOR_A_SDO);
		end
		return r;
	endfunction : sor_route

	function automatic logic sor_cfg_ok(input logic [CFG_W-1:0] n);
		return (n >= 5'h01) && (n <= 5'h1b);
	endfunction : sor_cfg_ok

endpackage : sor_pkg

// ===== rtl/sor_pulse_gen.sv
`timescale 1ns/1ps
module sor_pulse_gen #(
	parameter int MAX_W = 12
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_ce,
	input  wire logic             i_hold,
	input  wire logic [3:0]       i_res_bits,
	input  wire logic [7:0]       i_clk_div,
	input  wire logic [MAX_W-1:0] i_duty,
	output logic                  o_pulse
);
	import sor_pkg::*;

	typedef struct packed {
		logic [7:0]       pre;
		logic [MAX_W-1:0] cnt;
		logic [MAX_W-1:0] duty;
		logic             pulse;
	} sor_pg_state_t;

	sor_pg_state_t st_reg;
	sor_pg_state_t st_next;
	logic [MAX_W-1:0] top;

	// period is 2^res ticks of the divided clock
	always_comb begin
		top = MAX_W'((1 << i_res_bits) - 1);
	end

	always_comb begin
		st_next = st_reg;
		if (i_hold) begin
			st_next.cnt   = '0;
			st_next.pre   = '0;
			st_next.pulse = 1'b0;
		end else if (st_reg.pre >= i_clk_div) begin
			st_next.pre = '0;
			if (st_reg.cnt >= top) begin
				st_next.cnt  = '0;
				st_next.duty = i_duty;
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
			st_next.pulse = (st_next.cnt < st_next.duty);
		end else begin
			st_next.pre = st_reg.pre + 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_pulse = st_reg.pulse;

	a_hold_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && i_hold |=> !o_pulse)
		else $error("pulse not suspended");

endmodule : sor_pulse_gen

// ===== rtl/sor_threshold_cmp.sv
`timescale 1ns/1ps
module sor_threshold_cmp (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_ce,
	input  wire logic                      i_sample,
	input  wire logic [sor_pkg::RES_W-1:0] i_value,
	input  wire sor_pkg::sor_cmp_cfg_t     i_cfg,
	output logic                           o_flag
);
	import sor_pkg::*;

	typedef struct packed {
		logic             raw;
		logic             flag;
		logic [DLY_W-1:0] dly;
	} sor_tc_state_t;

	sor_tc_state_t st_reg;
	sor_tc_state_t st_next;
	logic          hit;
	logic [RES_W:0] hi_h;
	logic [RES_W:0] lo_h;

	always_comb begin
		st_next = st_reg;
		// hysteresis: once active the band widens by hyst
		hi_h = {1'b0, i_cfg.thr_hi} + (st_reg.raw ? {1'b0, i_cfg.hyst} : '0);
		lo_h = (st_reg.raw && i_cfg.thr_lo > i_cfg.hyst) ?
			{1'b0, i_cfg.thr_lo - i_cfg.hyst} : {1'b0, i_cfg.thr_lo};
		if (i_cfg.window) begin
			hit = ({1'b0, i_value} >= lo_h) && ({1'b0, i_value} <= hi_h);
		end else begin
			hit = st_reg.raw ? ({1'b0, i_value} + {1'b0, i_cfg.hyst} >
				{1'b0, i_cfg.thr_hi}) : (i_value > i_cfg.thr_hi);
		end
		if (i_sample) begin
			st_next.raw = hit;
		end
		if ((st_reg.raw ^ i_cfg.invert) == st_reg.flag) begin
			st_next.dly = '0;
		end else if (st_reg.dly >= (st_reg.flag ? i_cfg.off_dly : i_cfg.on_dly)) begin
			st_next.flag = ~st_reg.flag;
			st_next.dly  = '0;
		end else begin
			st_next.dly = st_reg.dly + 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_flag = st_reg.flag;

endmodule : sor_threshold_cmp

// ===== test/sor_host_model.sv
`timescale 1ns/1ps
// host controller on the serial side: one-wire request, exit, spi traffic
module sor_host_model (
	input  wire logic i_sys_clk,
	input  wire logic i_do_req,
	input  wire logic i_do_exit,
	input  wire logic i_do_spi,
	output logic      o_ow_request,
	output logic      o_ow_set_exit,
	output logic      o_spi_busy,
	output logic      o_spi_sdo,
	output logic      o_spi_ss_n
);
	initial begin
		{o_ow_request, o_ow_set_exit, o_spi_busy, o_spi_sdo} = 4'h0;
		o_spi_ss_n = 1'b1;
	end
	// launched on the rising edge so the falling-edge stimulus never races it
	always @(posedge i_sys_clk) begin
		o_ow_request  <= i_do_req;
		o_ow_set_exit <= i_do_exit;
		o_spi_busy    <= i_do_spi;
		o_spi_ss_n    <= !i_do_spi;
		// data line never holds a stale value, so keep it moving
		o_spi_sdo     <= !o_spi_sdo;
	end
endmodule : sor_host_model

// ===== test/sor_output_routing_bench.sv
`timescale 1ns/1ps
module sor_output_routing_bench;
	import sor_pkg::*;
	localparam int SC = 50;
	logic         clk, rstn, valid, spi_sel, win_en, req, ex, spi, stall, alive;
	logic         ow_req, ow_ex, busy, sdo, ssn, owa, f1, f2, diag, cfe, cef;
	logic         boe, dac_en, cmd, pina, pinb, aoe, sso, mpin, mpe, ce;
	logic [4:0]   cfg;
	logic [1:0]   dsrc, sif;
	logic [14:0]  br, t1, t2;
	logic [10:0]  dac;
	logic [7:0]   ecode;
	sor_cmp_cfg_t ca;
	sor_err_in_t  err;
	int           mismatches, n_compared, tc;
	sor_host_model sor_host_model_inst (.i_sys_clk(clk), .i_do_req(req),
		.i_do_exit(ex), .i_do_spi(spi), .o_ow_request(ow_req),
		.o_ow_set_exit(ow_ex), .o_spi_busy(busy), .o_spi_sdo(sdo),
		.o_spi_ss_n(ssn));
	sor_output_routing #(.START_CYC(SC), .WDOG_LIM(40)) sor_output_routing_inst (
		.i_sys_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_bridge_res(br),
		.i_temp1_res(t1), .i_temp2_res(t2), .i_res_valid(valid),
		.i_out_cfg(cfg), .i_spi_sel(spi_sel), .i_start_win_en(win_en),
		.i_dac_src(dsrc), .i_pulse_src(dsrc), .i_pulse_res(4'h9),
		.i_pulse_div(8'h00), .i_cmp_a_cfg(ca), .i_cmp_b_cfg(ca),
		.i_ow_request(ow_req), .i_ow_set_exit(ow_ex), .i_spi_busy(busy),
		.i_spi_sdo(sdo), .i_spi_ss_n_pin(ssn), .i_ctrl_alive(alive),
		.i_loop_tick(alive), .i_err(err), .o_dac_code(dac), .o_dac_en(dac_en),
		.o_main_pulse_en(mpe), .o_main_pin_driver(mpin),
		.o_dual_pin_driver(pina), .o_dual_use_pin_a_oe(aoe),
		.o_dual_use_pin_b_oe(boe), .o_dual_use_pin_b(pinb),
		.o_onewire_active(owa), .o_serial_if(sif),
		.o_command_mode(cmd), .o_spi_ss_n(sso), .o_first_threshold_flag(f1),
		.o_second_threshold_flag(f2), .o_diag_mode(diag),
		.o_ctrl_err_flag(cef), .o_err_code(ecode), .o_cfg_err(cfe));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// controller heartbeat: both toggles move together unless stalled
	always @(negedge clk) begin
		tc <= tc + 1;
		if (!stall && tc % 8 == 0)
			alive <= !alive;
	end
	function automatic logic [10:0] exp_dac(input logic [1:0] s);
		return 11'(((s == 2'd0) ? br : (s == 2'd1) ? t1 : t2) >> 4);
	endfunction : exp_dac
	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string m);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t: %s", $time, m);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	task automatic start(input logic w, input logic [4:0] c);
		@(negedge clk);
		rstn = 1'b0;
		{win_en, cfg, spi_sel} = {w, c, c > 5'd18};
		{err, req, ex, spi, stall, valid} = '0;
		wt(10);
		rstn = 1'b1;
		// the internal reset copy lets go two edges later
		wt(3);
	endtask : start
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		{rstn, valid, spi_sel, win_en, req, ex, spi, stall, alive} = '0;
		{br, t1, t2, dsrc, cfg, err, tc, mismatches, n_compared} = '0;
		ca = '0;
		ce = 1'b1;
		ca.thr_hi = 15'h4000;
		void'($urandom(65));
		start(1'b1, 5'd7);
		ce = 1'b0;
		wt(SC + 10);
		chk(owa, 1, "window frozen by enable");
		ce = 1'b1;
		wt(5);
		chk(owa, 1, "one-wire in window");
		wt(SC + 5);
		chk(sif, 16'(SOR_IF_I2C), "i2c after window");
		chk(dac_en, 1, "dac enable");
		repeat (8) begin
			{br, t1, t2} = {15'($urandom), 15'($urandom), 15'($urandom)};
			dsrc = 2'($urandom % 3);
			wt(4);
			chk(dac, exp_dac(dsrc), "dac code");
		end
		$display("test window done");
		start(1'b1, 5'd7);
		req = 1'b1;
		wt(12);
		req = 1'b0;
		wt(SC);
		chk({owa, cmd}, 2'b11, "command mode held");
		ex = 1'b1;
		wt(1);
		ex = 1'b0;
		wt(6);
		chk(owa, 0, "left one-wire");
		$display("test request done");
		start(1'b0, 5'd27);
		{br, valid, spi} = {15'h7000, 2'b11};
		wt(1);
		valid = 1'b0;
		wt(6);
		chk(sif, 16'(SOR_IF_SPI), "window skipped");
		chk({f2, boe}, 2'b00, "no second flag in spi");
		chk({aoe, sso, mpin}, 3'b100, "spi owns pin a");
		spi = 1'b0;
		start(1'b0, 5'd4);
		// temperatures stay high throughout: they must never raise a flag
		{t1, t2, ca.thr_lo} = {15'h7fff, 15'h7fff, 15'h0800};
		for (int k = 0; k < 4; k++) begin
			// 2: inside the window band, 3: direction inverted
			{ca.window, ca.invert} = {k == 2, k == 3};
			br = (k == 0 || k == 3) ? 15'h7000 : 15'h1000;
			valid = 1'b1;
			wt(1);
			valid = 1'b0;
			wt(6);
			chk({f1, f2, pina, pinb}, k[0] ? 4'h0 : 4'hf, "flags");
		end
		$display("test flags done");
		start(1'b0, 5'd13);
		{br, dsrc} = {15'h7fff, 2'd0};
		wt(530);
		chk({mpe, mpin}, 2'b11, "pulse on main pin");
		$display("test pulse done");
		for (int n = 0; n < 32; n++) begin
			start(1'b0, 5'(n));
			wt(6);
			chk(cfe, !(n >= 1 && n <= 27), "cfg check");
		end
		$display("test cfg done");
		for (int k = 0; k < 5; k++) begin
			start(1'b0, 5'd7);
			wt(6);
			err.err_high = k[0];
			case (k)
				0: err.mem_fail = 1'b1;
				1: err.wire_p_bad = 1'b1;
				2: err.sensor_aging = 1'b1;
				3: stall = 1'b1;
				default: err.parity_fail = 1'b1;
			endcase
			wt(60);
			chk(diag, 1, "diag mode");
			chk(ecode, (k == 0) ? ERR_MEM : (k == 1) ? ERR_WIRE : (k == 2) ?
				ERR_AGE : (k == 3) ? ERR_WDOG : ERR_SIG, "code");
			chk(dac, k[0] ? DAC_MAX : DAC_MIN, "diag level");
			if (k == 4)
				chk(cef, 1, "controller error flag");
		end
		$display("test errors done");
		print_verdict();
	end
	initial begin
		#400000;
		mismatches++;
		print_verdict();
	end
endmodule : sor_output_routing_bench
